// >>> lsr_pkg.sv
// Purpose: Constants and types of the leak sensor register map
// Assumes: 200 MHz mclk, 16-bit register words addressed by word index
// Notes:   Measurement values are signed tenths of their unit
package lsr_pkg;
   // Word addresses of the register map
   localparam logic [15:0] ADDR_SOFT_RESET = 16'h0101;
   localparam logic [15:0] ADDR_RUN_STATE  = 16'h0110;
   localparam logic [15:0] ADDR_ALARM_FLAG = 16'h0111;
   localparam logic [15:0] ADDR_FAULT_MAP  = 16'h0112;
   localparam logic [15:0] ADDR_GAS_LEVEL  = 16'h0113;
   localparam logic [15:0] ADDR_TEMP       = 16'h0114;
   localparam logic [15:0] ADDR_HUMIDITY   = 16'h0115;
   localparam logic [15:0] ADDR_SLAVE_ID   = 16'h0120;
   localparam logic [15:0] ADDR_THRESHOLD  = 16'h0124;
   localparam logic [15:0] ADDR_MARKING    = 16'h0140;
   localparam logic [15:0] MARKING_WORDS   = 16'h000a;
   localparam logic [15:0] ADDR_FW_REV     = 16'h014a;
   localparam logic [15:0] ADDR_GAS_TYPE   = 16'h014c;
   localparam logic [15:0] ADDR_SVC_DAYS   = 16'h014e;

   // Fault bitmap positions
   localparam int FB_INTERNAL = 0;
   localparam int FB_RANGE    = 1;
   localparam int FB_SELFCHK  = 3;
   localparam int FB_DEAD     = 4;
   localparam int FB_LIFE     = 5;

   // Reset values
   localparam logic [7:0]  SLAVE_ID_RST  = 8'h01;
   localparam logic [15:0] THRESHOLD_RST = 16'h00fa;
   localparam logic [15:0] SOFT_RESET_GO = 16'h0001;

   // Value limits; measurement limits in tenths
   localparam logic [7:0]         SLAVE_ID_MIN = 8'h01;
   localparam logic [7:0]         SLAVE_ID_MAX = 8'hf7;
   localparam logic signed [15:0] GAS_MIN      = 16'sh0000;
   localparam logic signed [15:0] GAS_MAX      = 16'sh03e8;
   localparam logic signed [15:0] TEMP_MIN     = -16'sh0190;
   localparam logic signed [15:0] TEMP_MAX     = 16'sh04e2;
   localparam logic signed [15:0] HUM_MIN      = 16'sh0000;
   localparam logic signed [15:0] HUM_MAX      = 16'sh03e8;
   localparam logic [15:0]        DAYS_MAX     = 16'hffff;

   // Timing: clock, second, alarm hold and day length
   localparam int CLK_PERIOD_NS = 5;
   localparam int SECOND_NS     = 1_000_000_000;
   localparam int SEC_CYC       = SECOND_NS / CLK_PERIOD_NS;
   localparam int HOLD_MINUTES  = 5;
   localparam int HOLD_SEC      = HOLD_MINUTES * 60;
   localparam int DAY_SEC       = 86400;

   typedef enum logic {RS_STARTUP, RS_MEASURING} lsr_run_t;

   typedef struct packed {
      logic [31:0]        sec_cnt;
      logic [16:0]        day_sec;
      logic [15:0]        hold_sec;
      logic               alarm;
      lsr_run_t           run;
      logic signed [15:0] gas;
      logic signed [15:0] temp;
      logic signed [15:0] hum;
      logic               range_err;
      logic [7:0]         slave_id;
      logic [7:0]         active_id;
      logic [15:0]        thresh;
      logic [15:0]        days;
      logic [15:0]        rdata;
      logic               ack;
      logic               err;
      logic               soft_rst;
   } lsr_state_t;
endpackage

// >>> lsr_regmap.sv
// Purpose: Register bank of a refrigerant leak sensor behind a bus protocol engine
// Assumes: Protocol engine and measurement logic run on mclk, one access per strobe
// Notes:   Access answered one cycle after its strobe; errors become exceptions
`timescale 1ns/100ps

// Summary of operation
// - Run state reads 0 startup, 1 measuring
// - Alarm sets when gas exceeds threshold
// - Alarm held five minutes after leak ends
// - Alarm reads 1 during leak or hold
// - Fault bit 0 flags internal fault
// - Fault bit 1 flags out-of-limit measurement
// - Fault bit 3 flags failed self-check
// - Fault bit 4 flags unrecoverable sensor
// - Fault bit 5 flags service life reached
// - Gas level signed tenths, clamped 0-100
// - Temperature signed tenths, -40 to 125
// - Humidity signed tenths, 0 to 100
// - Slave id writable 1-247, default 1
// - New slave id applies after soft reset only
// - Threshold register drives the alarm comparison
// - Marking string over ten read-only words
// - Firmware version major high, minor low
// - Gas type 0 or 1 enumeration
// - Service days counted, readable by master
// - Writing 1 to reset word resets softly
module lsr_regmap #(
   parameter int             SEC_CYCLES      = lsr_pkg::SEC_CYC,
   parameter int             HOLD_SECONDS    = lsr_pkg::HOLD_SEC,
   parameter int             DAY_SECONDS     = lsr_pkg::DAY_SEC,
   parameter logic [15:0]    LIFE_LIMIT_DAYS = 16'h0e42,
   parameter logic [159:0]   MARKING_TEXT    = 160'h4c45414b5f53454e534f52000000000000000000,
   parameter logic [15:0]    FW_REVISION     = 16'h0100,
   parameter logic [15:0]    GAS_TYPE_CODE   = 16'h0001
) (
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire logic                reg_rd,
   input  wire logic                reg_wr,
   input  wire logic [15:0]         reg_addr,
   input  wire logic [15:0]         reg_wdata,
   output logic [15:0]              reg_rdata,
   output logic                     reg_ack,
   output logic                     reg_err,
   input  wire logic                meas_valid,
   input  wire logic signed [15:0]  meas_gas,
   input  wire logic signed [15:0]  meas_temp,
   input  wire logic signed [15:0]  meas_hum,
   input  wire logic                internal_fault,
   input  wire logic                self_check_fail,
   input  wire logic                sensor_dead,
   output logic [7:0]               active_slave_id,
   output logic                     soft_reset_pulse,
   output logic                     leak_alarm
);
   import lsr_pkg::*;

   lsr_state_t st_r;
   lsr_state_t st_nxt;
   logic       sec_tick;
   logic       leak_now;
   logic [15:0] fault_word;
   logic       acc;

   // Marking words occupy a contiguous window
   function automatic logic is_marking(input logic [15:0] a);
      return (a >= ADDR_MARKING) && (a < ADDR_MARKING + MARKING_WORDS);
   endfunction

   // Picks one marking word, first characters in the first word
   function automatic logic [15:0] marking_word(input logic [15:0] a);
      logic [15:0] w;
      logic [3:0]  idx;
      w   = 16'h0000;
      idx = 4'(a - ADDR_MARKING);
      for (int i = 0; i < 10; i++) begin
         if (idx == 4'(i)) begin
            w = MARKING_TEXT[159 - 16*i -: 16];
         end
      end
      return w;
   endfunction

   // Clamps a value into a signed window
   function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                input logic signed [15:0] lo,
                                                input logic signed [15:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   // Shared decode terms
   assign sec_tick = (st_r.sec_cnt == 32'(SEC_CYCLES - 1));
   assign leak_now = (st_r.run == RS_MEASURING) && ($unsigned(st_r.gas) > st_r.thresh);
   assign acc      = reg_rd | reg_wr;

   // Fault bitmap assembly
   always_comb begin
      fault_word              = 16'h0000;
      fault_word[FB_INTERNAL] = internal_fault;
      fault_word[FB_RANGE]    = st_r.range_err;
      fault_word[FB_SELFCHK]  = self_check_fail || (st_r.thresh > 16'(GAS_MAX));
      fault_word[FB_DEAD]     = sensor_dead;
      fault_word[FB_LIFE]     = (st_r.days >= LIFE_LIMIT_DAYS);
   end

   // Next state of the whole block
   always_comb begin
      st_nxt          = st_r;
      st_nxt.ack      = acc;
      st_nxt.err      = 1'b0;
      st_nxt.soft_rst = 1'b0;
      st_nxt.sec_cnt  = sec_tick ? 32'h0000_0000 : st_r.sec_cnt + 32'h0000_0001;

      // Elapsed service time in days
      if (sec_tick) begin
         if (st_r.day_sec == 17'(DAY_SECONDS - 1)) begin
            st_nxt.day_sec = 17'h00000;
            if (st_r.days != DAYS_MAX) begin
               st_nxt.days = st_r.days + 16'h0001;
            end
         end else begin
            st_nxt.day_sec = st_r.day_sec + 17'h00001;
         end
      end

      // Latest measurement capture
      if (meas_valid) begin
         st_nxt.run       = RS_MEASURING;
         st_nxt.gas       = clamp(meas_gas, GAS_MIN, GAS_MAX);
         st_nxt.temp      = meas_temp;
         st_nxt.hum       = meas_hum;
         st_nxt.range_err = (meas_gas < GAS_MIN) || (meas_gas > GAS_MAX) ||
                            (meas_temp < TEMP_MIN) || (meas_temp > TEMP_MAX) ||
                            (meas_hum < HUM_MIN) || (meas_hum > HUM_MAX);
      end

      // Leak alarm with post-leak hold
      if (leak_now) begin
         st_nxt.alarm    = 1'b1;
         st_nxt.hold_sec = 16'(HOLD_SECONDS);
      end else if (st_r.alarm && sec_tick) begin
         if (st_r.hold_sec == 16'h0000) begin                             // Full hold spent before clearing
            st_nxt.alarm    = 1'b0;
            st_nxt.hold_sec = 16'h0000;
         end else begin
            st_nxt.hold_sec = st_r.hold_sec - 16'h0001;
         end
      end

      // Soft reset one cycle after its write
      if (st_r.soft_rst) begin
         st_nxt.active_id = st_r.slave_id;
         st_nxt.run       = RS_STARTUP;
      end

      // Register reads
      st_nxt.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_RUN_STATE:  st_nxt.rdata = 16'(st_r.run);
            ADDR_ALARM_FLAG: st_nxt.rdata = {15'h0000, st_r.alarm};
            ADDR_FAULT_MAP:  st_nxt.rdata = fault_word;
            ADDR_GAS_LEVEL:  st_nxt.rdata = st_r.gas;
            ADDR_TEMP:       st_nxt.rdata = st_r.temp;
            ADDR_HUMIDITY:   st_nxt.rdata = st_r.hum;
            ADDR_SLAVE_ID:   st_nxt.rdata = {8'h00, st_r.slave_id};
            ADDR_THRESHOLD:  st_nxt.rdata = st_r.thresh;
            ADDR_FW_REV:     st_nxt.rdata = FW_REVISION;
            ADDR_GAS_TYPE:   st_nxt.rdata = GAS_TYPE_CODE;
            ADDR_SVC_DAYS:   st_nxt.rdata = st_r.days;
            default: begin
               if (is_marking(reg_addr)) begin
                  st_nxt.rdata = marking_word(reg_addr);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
         endcase
      end

      // Register writes; read-only words and bad values refused
      if (reg_wr) begin
         st_nxt.rdata = reg_wdata;
         unique case (reg_addr)
            ADDR_SLAVE_ID: begin
               if (reg_wdata >= 16'(SLAVE_ID_MIN) && reg_wdata <= 16'(SLAVE_ID_MAX)) begin
                  st_nxt.slave_id = reg_wdata[7:0];
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            ADDR_THRESHOLD: st_nxt.thresh = reg_wdata;
            ADDR_SOFT_RESET: begin
               if (reg_wdata == SOFT_RESET_GO) begin
                  st_nxt.soft_rst = 1'b1;
               end else if (reg_wdata != 16'h0000) begin
                  st_nxt.err = 1'b1;
               end
            end
            default: st_nxt.err = 1'b1;
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r           <= '0;
         st_r.run       <= RS_STARTUP;
         st_r.slave_id  <= SLAVE_ID_RST;
         st_r.active_id <= SLAVE_ID_RST;
         st_r.thresh    <= THRESHOLD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign reg_rdata        = st_r.rdata;
   assign reg_ack          = st_r.ack;
   assign reg_err          = st_r.err;
   assign active_slave_id  = st_r.active_id;
   assign soft_reset_pulse = st_r.soft_rst;
   assign leak_alarm       = st_r.alarm;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_reset_write;
      reg_wr && (reg_addr == ADDR_SOFT_RESET) && (reg_wdata == SOFT_RESET_GO);
   endsequence

   sequence s_reset_done;
      soft_reset_pulse ##1 (st_r.run == RS_STARTUP);
   endsequence

   a_run_starts: assert property ($rose(st_r.run == RS_MEASURING) |-> $past(meas_valid))
      else $error("run state entered measuring without a measurement");
   a_alarm_sets: assert property (leak_now |=> leak_alarm)
      else $error("alarm not set while gas above threshold");
   a_alarm_holds: assert property ($fell(leak_alarm) |-> $past(sec_tick) && !$past(leak_now))
      else $error("alarm dropped outside hold expiry");
   a_hold_reload: assert property (leak_now |=> st_r.hold_sec == 16'(HOLD_SECONDS))
      else $error("hold time not reloaded during leak");
   a_fault_unused: assert property (fault_word[2] == 1'b0 && fault_word[15:6] == 10'h000)
      else $error("unused fault bit set");
   a_gas_clamped: assert property (st_r.gas >= GAS_MIN && st_r.gas <= GAS_MAX)
      else $error("gas level outside clamp window");
   a_slave_range: assert property (st_r.slave_id >= SLAVE_ID_MIN && st_r.slave_id <= SLAVE_ID_MAX)
      else $error("slave id outside legal range");
   a_id_sticky: assert property ($changed(active_slave_id) |-> $past(soft_reset_pulse))
      else $error("active slave id changed without soft reset");
   a_soft_reset: assert property (s_reset_write |=> s_reset_done)
      else $error("soft reset write not carried out");
   a_days_hold: assert property (st_r.days == DAYS_MAX |=> st_r.days == DAYS_MAX)
      else $error("service day counter wrapped");

   // Marking words answer without an exception
   a_marking_read: assert property (reg_rd && is_marking(reg_addr) |=> reg_ack && !reg_err)
      else $error("marking read refused");

   sequence s_fault_read;
      reg_rd && (reg_addr == ADDR_FAULT_MAP);
   endsequence

   sequence s_out_of_limit;
      meas_valid && ((meas_temp < TEMP_MIN) || (meas_temp > TEMP_MAX) || (meas_hum > HUM_MAX));
   endsequence

   sequence s_id_bad_write;
      reg_wr && (reg_addr == ADDR_SLAVE_ID) && ((reg_wdata < 16'(SLAVE_ID_MIN)) || (reg_wdata > 16'(SLAVE_ID_MAX)));
   endsequence

   // Run state word carries one bit only
   a_run_values: assert property (reg_rd && (reg_addr == ADDR_RUN_STATE) |=> reg_rdata[15:1] == 15'h0000)
      else $error("run state word out of range");

   // Startup left only by a measurement
   a_run_restart: assert property (st_r.run == RS_STARTUP && !meas_valid |=> st_r.run == RS_STARTUP)
      else $error("run state left startup on its own");

   // Alarm raised only by a leak
   a_alarm_source: assert property (!leak_alarm && !leak_now |=> !leak_alarm)
      else $error("alarm raised without a leak");

   // Alarm kept while hold time remains
   a_alarm_stays: assert property (leak_alarm && (st_r.hold_sec != 16'h0000) |=> leak_alarm)
      else $error("alarm cleared before hold time ran out");

   // Hold counter never above its load value
   a_hold_bound: assert property (st_r.hold_sec <= 16'(HOLD_SECONDS))
      else $error("hold counter above its load value");

   // Alarm word mirrors the flag
   a_alarm_read: assert property (reg_rd && (reg_addr == ADDR_ALARM_FLAG) |=> reg_rdata == {15'h0000, $past(leak_alarm)})
      else $error("alarm word differs from flag");

   // Internal fault shown live in bit 0
   a_fault_internal: assert property (s_fault_read |=> reg_rdata[FB_INTERNAL] == $past(internal_fault))
      else $error("internal fault bit wrong");

   // Out-of-limit measurement flags bit 1
   a_range_sets: assert property (s_out_of_limit |=> st_r.range_err)
      else $error("out-of-limit measurement not flagged");

   // Failed self-check shows in bit 3
   a_selfchk_flag: assert property (self_check_fail |-> fault_word[FB_SELFCHK])
      else $error("self-check bit missing");

   // Dead sensor shows in bit 4
   a_dead_flag: assert property (sensor_dead |-> fault_word[FB_DEAD])
      else $error("dead sensor bit missing");

   // Service limit shows in bit 5
   a_life_flag: assert property ((st_r.days >= LIFE_LIMIT_DAYS) |-> fault_word[FB_LIFE])
      else $error("service limit bit missing");

   // In-window gas value stored unchanged
   a_gas_capture: assert property (meas_valid && (meas_gas >= GAS_MIN) && (meas_gas <= GAS_MAX) |=> st_r.gas == $past(meas_gas))
      else $error("gas value not captured");

   // Gas word returns the stored level
   a_gas_read: assert property (reg_rd && (reg_addr == ADDR_GAS_LEVEL) |=> reg_rdata == $past(st_r.gas))
      else $error("gas word differs from stored level");

   // Temperature taken from the strobe
   a_temp_capture: assert property (meas_valid |=> st_r.temp == $past(meas_temp))
      else $error("temperature not captured");

   // Humidity taken from the strobe
   a_hum_capture: assert property (meas_valid |=> st_r.hum == $past(meas_hum))
      else $error("humidity not captured");

   // Illegal slave id refused and kept
   a_id_refused: assert property (s_id_bad_write |=> reg_err && $stable(st_r.slave_id))
      else $error("illegal slave id accepted");

   // Slave id word returns the stored id
   a_id_read: assert property (reg_rd && (reg_addr == ADDR_SLAVE_ID) |=> reg_rdata == {8'h00, $past(st_r.slave_id)})
      else $error("slave id word differs from stored id");

   // Writing the id leaves the active id alone
   a_id_kept: assert property (reg_wr && (reg_addr == ADDR_SLAVE_ID) && !soft_reset_pulse |=> $stable(active_slave_id))
      else $error("active id changed by id write");

   // Threshold write lands as written
   a_thresh_write: assert property (reg_wr && (reg_addr == ADDR_THRESHOLD) |=> st_r.thresh == $past(reg_wdata))
      else $error("threshold write lost");

   // Firmware word is the build constant
   a_fw_read: assert property (reg_rd && (reg_addr == ADDR_FW_REV) |=> reg_rdata == FW_REVISION)
      else $error("firmware word wrong");

   // Gas type word is the build constant
   a_gas_type: assert property (reg_rd && (reg_addr == ADDR_GAS_TYPE) |=> reg_rdata == GAS_TYPE_CODE)
      else $error("gas type word wrong");

   // Service days move by one at a time
   a_days_step: assert property ($changed(st_r.days) |-> (st_r.days == $past(st_r.days) + 16'h0001))
      else $error("service days jumped");

   // Service days move only on a second tick
   a_days_ticks: assert property (!sec_tick |=> $stable(st_r.days))
      else $error("service days moved between ticks");

   // Reset word other than one starts nothing
   a_reset_refused: assert property (reg_wr && (reg_addr == ADDR_SOFT_RESET) && (reg_wdata != SOFT_RESET_GO) |=> !soft_reset_pulse)
      else $error("soft reset from wrong value");

   // Unused fault bits read back as zero
   a_unused_read: assert property (s_fault_read |=> (reg_rdata[2] == 1'b0) && (reg_rdata[15:6] == 10'h000))
      else $error("unused fault bit read as one");
endmodule

// >>> lsr_master_model.sv
// Purpose: Bus master model for the register strobe bus
// Assumes: Answer arrives one cycle after the strobe
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/100ps
module lsr_master_model (
   input  wire logic        mclk,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_ack,
   input  wire logic        reg_err
);
   // Idle bus at time zero
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end

   // One strobe pulse, then a bounded wait for the answer
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic e, output logic ok);
      int n;
      n = 0;
      @(posedge mclk);
      reg_rd <= ~wr;
      reg_wr <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      do begin
         @(posedge mclk);
         n++;
      end while (reg_ack !== 1'b1 && n < 4);
      q = reg_rdata;
      e = reg_err;
      ok = (reg_ack === 1'b1);
   endtask
endmodule

// >>> lsr_regmap_tb.sv
// Purpose: Self-checking bench for the leak sensor register bank
// Assumes: Second, hold and day lengths shortened by parameters
// Notes:   Register accesses go through the master model
`timescale 1ns/100ps
module lsr_regmap_tb;
   import lsr_pkg::*;
   localparam logic [15:0]  LIFE = 16'h0190;
   localparam logic [159:0] MARK = 160'h4741535f53454e534f525f554e49540000000000;
   localparam logic [15:0]  FW   = 16'h0203;
   localparam logic [15:0]  GAST = 16'h0000;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        reg_rd;
   logic        reg_wr;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_ack;
   logic        reg_err;
   logic        meas_valid;
   logic [15:0] meas_gas;
   logic [15:0] meas_temp;
   logic [15:0] meas_hum;
   logic [2:0]  flt;
   logic [7:0]  active_slave_id;
   logic        soft_reset_pulse;
   logic        leak_alarm;
   int          miscompares = 0;
   int          n_checks = 0;

   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   lsr_master_model i_lsr_master_model (.mclk(mclk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

   lsr_regmap #(.SEC_CYCLES(4), .HOLD_SECONDS(3), .DAY_SECONDS(5), .LIFE_LIMIT_DAYS(LIFE), .MARKING_TEXT(MARK),
      .FW_REVISION(FW), .GAS_TYPE_CODE(GAST)) i_lsr_regmap (.mclk(mclk), .rst_b(rst_b), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_err(reg_err), .meas_valid(meas_valid), .meas_gas(meas_gas), .meas_temp(meas_temp),
      .meas_hum(meas_hum), .internal_fault(flt[0]), .self_check_fail(flt[1]), .sensor_dead(flt[2]),
      .active_slave_id(active_slave_id), .soft_reset_pulse(soft_reset_pulse), .leak_alarm(leak_alarm));

   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // One access with answer, exception and read data compared
   task automatic xfer(input logic wr, input string what, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] xq, input logic xe);
      logic [15:0] q;
      logic        e;
      logic        ok;
      i_lsr_master_model.access(wr, a, d, q, e, ok);
      check({what, " ack"}, {15'h0, ok}, 16'h0001);
      check({what, " err"}, {15'h0, e}, {15'h0, xe});
      if (!wr && !xe) begin
         check(what, q, xq);
      end
   endtask

   // One measurement strobe
   task automatic meas(input logic [15:0] g, input logic [15:0] t, input logic [15:0] h);
      @(posedge mclk);
      meas_valid <= 1'b1;
      meas_gas <= g;
      meas_temp <= t;
      meas_hum <= h;
      @(posedge mclk);
      meas_valid <= 1'b0;
   endtask

   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      summarize();
   end

   // Main sequence
   initial begin
      logic [15:0] q0;
      logic [15:0] q1;
      logic        e;
      logic        ok;
      int          n;
      meas_valid = 1'b0;
      meas_gas = 16'h0000;
      meas_temp = 16'h0000;
      meas_hum = 16'h0000;
      flt = 3'h0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      xfer(1'b0, "run_state", ADDR_RUN_STATE, 16'h0, 16'h0000, 1'b0);
      xfer(1'b0, "alarm", ADDR_ALARM_FLAG, 16'h0, 16'h0000, 1'b0);
      xfer(1'b0, "slave_id", ADDR_SLAVE_ID, 16'h0, 16'h0001, 1'b0);
      xfer(1'b0, "threshold", ADDR_THRESHOLD, 16'h0, THRESHOLD_RST, 1'b0);
      xfer(1'b0, "fw_rev", ADDR_FW_REV, 16'h0, FW, 1'b0);
      xfer(1'b0, "gas_type", ADDR_GAS_TYPE, 16'h0, GAST, 1'b0);
      for (int k = 0; k < 10; k++) begin
         xfer(1'b0, "marking", ADDR_MARKING + 16'(k), 16'h0, MARK[159 - 16 * k -: 16], 1'b0);
      end
      $display("test reset_values done");
      meas(16'h0064, 16'h00d2, 16'h0131);
      xfer(1'b0, "run_state", ADDR_RUN_STATE, 16'h0, 16'h0001, 1'b0);
      xfer(1'b0, "gas", ADDR_GAS_LEVEL, 16'h0, 16'h0064, 1'b0);
      xfer(1'b0, "temp", ADDR_TEMP, 16'h0, 16'h00d2, 1'b0);
      xfer(1'b0, "hum", ADDR_HUMIDITY, 16'h0, 16'h0131, 1'b0);
      for (int i = 0; i < 3; i++) begin
         flt <= 3'(3'h1 << i);
         xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'(16'h0001 << (i == 0 ? 0 : i + 2)), 1'b0);
      end
      flt <= 3'h0;
      meas(16'hfffb, 16'h04e2, 16'h03e8);
      xfer(1'b0, "gas", ADDR_GAS_LEVEL, 16'h0, 16'h0000, 1'b0);
      xfer(1'b0, "temp", ADDR_TEMP, 16'h0, 16'h04e2, 1'b0);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0002, 1'b0);
      meas(16'h0000, 16'hfe70, 16'h03e9);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0002, 1'b0);
      meas(16'h0000, 16'hfe6f, 16'h0000);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0002, 1'b0);
      meas(16'h0000, 16'hfe70, 16'h03e8);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0000, 1'b0);
      xfer(1'b1, "threshold", ADDR_THRESHOLD, 16'h03e9, 16'h0, 1'b0);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0008, 1'b0);
      xfer(1'b1, "threshold", ADDR_THRESHOLD, 16'h0064, 16'h0, 1'b0);
      xfer(1'b0, "threshold", ADDR_THRESHOLD, 16'h0, 16'h0064, 1'b0);
      $display("test measurements done");
      meas(16'h0064, 16'h00d2, 16'h0131);
      repeat (2) @(posedge mclk);
      check("leak_alarm", {15'h0, leak_alarm}, 16'h0000);
      meas(16'h0065, 16'h00d2, 16'h0131);
      repeat (2) @(posedge mclk);
      check("leak_alarm", {15'h0, leak_alarm}, 16'h0001);
      meas(16'h0400, 16'h00d2, 16'h0131);
      xfer(1'b0, "gas", ADDR_GAS_LEVEL, 16'h0, 16'h03e8, 1'b0);
      meas(16'h0064, 16'h00d2, 16'h0131);
      xfer(1'b0, "alarm", ADDR_ALARM_FLAG, 16'h0, 16'h0001, 1'b0);
      n = 3;
      while (leak_alarm === 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      check("hold length ok", 16'(n >= 14 && n <= 17), 16'h0001);
      xfer(1'b0, "alarm", ADDR_ALARM_FLAG, 16'h0, 16'h0000, 1'b0);
      $display("test alarm_hold done");
      xfer(1'b1, "slave_id", ADDR_SLAVE_ID, 16'h0005, 16'h0, 1'b0);
      xfer(1'b0, "slave_id", ADDR_SLAVE_ID, 16'h0, 16'h0005, 1'b0);
      check("active id", {8'h00, active_slave_id}, 16'h0001);
      xfer(1'b1, "slave_id", ADDR_SLAVE_ID, 16'h0001, 16'h0, 1'b0);
      xfer(1'b0, "slave_id", ADDR_SLAVE_ID, 16'h0, 16'h0001, 1'b0);
      xfer(1'b1, "slave_id", ADDR_SLAVE_ID, 16'h00f7, 16'h0, 1'b0);
      xfer(1'b0, "slave_id", ADDR_SLAVE_ID, 16'h0, 16'h00f7, 1'b0);
      xfer(1'b1, "soft_reset", ADDR_SOFT_RESET, 16'h0002, 16'h0, 1'b1);
      xfer(1'b1, "soft_reset", ADDR_SOFT_RESET, 16'h0000, 16'h0, 1'b0);
      check("reset pulse", {15'h0, soft_reset_pulse}, 16'h0000);
      xfer(1'b0, "soft_reset", ADDR_SOFT_RESET, 16'h0, 16'h0, 1'b1);
      xfer(1'b0, "unmapped", 16'h0130, 16'h0, 16'h0, 1'b1);
      xfer(1'b1, "run_state", ADDR_RUN_STATE, 16'h0001, 16'h0, 1'b1);
      check("active id", {8'h00, active_slave_id}, 16'h0001);
      xfer(1'b1, "soft_reset", ADDR_SOFT_RESET, 16'h0001, 16'h0, 1'b0);
      check("reset pulse", {15'h0, soft_reset_pulse}, 16'h0001);
      @(posedge mclk);
      check("active id", {8'h00, active_slave_id}, 16'h00f7);
      xfer(1'b0, "run_state", ADDR_RUN_STATE, 16'h0, 16'h0000, 1'b0);
      $display("test slave_id_reset done");
      i_lsr_master_model.access(1'b0, ADDR_SVC_DAYS, 16'h0, q0, e, ok);
      repeat (17) @(posedge mclk);
      i_lsr_master_model.access(1'b0, ADDR_SVC_DAYS, 16'h0, q1, e, ok);
      check("day step", q1 - q0, 16'h0001);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0000, 1'b0);
      repeat (8000) @(posedge mclk);
      xfer(1'b0, "faults", ADDR_FAULT_MAP, 16'h0, 16'h0020, 1'b0);
      $display("test service_days done");
      summarize();
   end
endmodule
